// File: sse_bank.sv
// Purpose: Socket event, mask, status, force, control and power registers
// Assumes: Memory requests arrive as single-cycle strobes already qualified
// Notes:   rst is the global reset; bus_reset_in is the bus reset input
`timescale 1ns/1ns
`default_nettype none
module sse_bank
  import sse_pkg::*;
#(
  parameter int CTRL_WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic bus_reset_in,
  input wire logic [31:0] socket_base,
  input wire sse_req_s req,
  input wire sse_sock_s sock,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic status_change_interrupt
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic win_hit;
  logic [11:0] off;
  logic wr_lane0;
  logic wr_flags;
  logic wr_enables;
  logic wr_inject;
  logic wr_control;
  logic wr_power;

  // Window hit is relative to the programmed memory base
  assign win_hit = (req.addr[31:SSE_WIN_BITS] == socket_base[31:SSE_WIN_BITS]);
  assign off = req.addr[11:0];
  assign wr_lane0 = req.wr && win_hit && req.be[0];
  assign wr_flags = wr_lane0 && (off == SSE_OFF_FLAGS);
  assign wr_enables = wr_lane0 && (off == SSE_OFF_ENABLES);
  assign wr_inject = wr_lane0 && (off == SSE_OFF_INJECT);
  assign wr_control = req.wr && win_hit && (off == SSE_OFF_CONTROL);
  assign wr_power = req.wr && win_hit && (off == SSE_OFF_POWER);

  // ----------------------------------------------------------------
  // Context and plain registers
  // ----------------------------------------------------------------
  logic [3:0] enables;
  logic [CTRL_WIDTH-1:0] control;
  logic [31:0] power;
  logic pme_en;
  logic ctx_clear;

  assign pme_en = power[SSE_BIT_PME_EN];
  // With PME on, context bits survive the bus reset
  assign ctx_clear = bus_reset_in && !pme_en;

  // Mask and control are context bits; power only answers global reset
  always_ff @(posedge ref_clk) begin
    if (rst || ctx_clear) begin
      enables <= SSE_RST_NIBBLE;
      control <= CTRL_WIDTH'(SSE_RST_WORD);
    end else begin
      if (wr_enables) begin
        enables <= req.wdata[3:0];
      end
      if (wr_control) begin
        control <= CTRL_WIDTH'(merge_be(32'(control), req.wdata, req.be));
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power <= SSE_RST_WORD;
    end else if (wr_power) begin
      power <= merge_be(power, req.wdata, req.be);
    end
  end

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  logic primed;
  logic prev_pwr;
  logic prev_det2;
  logic prev_det1;
  logic prev_card;
  logic prev_crst;
  logic card_rise;
  logic card_fall;
  logic card_evt;
  logic reset_exit;
  logic [3:0] set_vec;
  logic [3:0] flags;

  // Prime one cycle after reset so stale history makes no event
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      primed <= 1'b0;
      prev_pwr <= 1'b0;
      prev_det2 <= 1'b0;
      prev_det1 <= 1'b0;
      prev_card <= 1'b0;
      prev_crst <= 1'b0;
    end else begin
      primed <= 1'b1;
      prev_pwr <= sock.power_cycle_status;
      prev_det2 <= sock.detect_two_status;
      prev_det1 <= sock.detect_one_status;
      prev_card <= sock.card_status_in;
      prev_crst <= sock.card_reset_in;
    end
  end

  assign card_rise = primed && sock.card_status_in && !prev_card;
  assign card_fall = primed && !sock.card_status_in && prev_card;
  // CardBus cards flag rising edges only; 16-bit cards flag both
  assign card_evt = card_rise || (card_fall && !sock.cardbus_card);
  // Leaving card reset re-flags detect and card status bits still present
  assign reset_exit = primed && prev_crst && !sock.card_reset_in;

  // Mask has no say in setting; it only gates the interrupt
  assign set_vec[SSE_BIT_PWR] = (primed && (sock.power_cycle_status != prev_pwr))
                                || (wr_inject && req.wdata[SSE_BIT_PWR]);
  assign set_vec[SSE_BIT_DET2] = (primed && (sock.detect_two_status != prev_det2))
                                 || (reset_exit && sock.detect_two_status)
                                 || (wr_inject && req.wdata[SSE_BIT_DET2]);
  assign set_vec[SSE_BIT_DET1] = (primed && (sock.detect_one_status != prev_det1))
                                 || (reset_exit && sock.detect_one_status)
                                 || (wr_inject && req.wdata[SSE_BIT_DET1]);
  assign set_vec[SSE_BIT_CARD] = card_evt
                                 || (reset_exit && sock.card_status_in)
                                 || (wr_inject && req.wdata[SSE_BIT_CARD]);

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // One cell per event, all sharing the context clear
  for (genvar k = 0; k < SSE_NUM_EVT; k++) begin : g_flag
    sse_flag_cell u_cell (
      .ref_clk(ref_clk),
      .rst(rst),
      .ctx_clear(ctx_clear),
      .set_evt(set_vec[k]),
      .w1c(wr_flags && req.wdata[k]),
      .flag(flags[k])
    );
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic next_irq;

  // Level request; leftovers also fire, so software clears first
  assign next_irq = |(flags & enables);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_change_interrupt <= 1'b0;
    end else begin
      status_change_interrupt <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] next_rd_data;

  // Live status tells software the present socket levels
  assign status_word = SSE_STATUS_CAPS | {28'h0000000, sock.power_cycle_status,
                       sock.detect_two_status, sock.detect_one_status, sock.card_status_in};

  // Unmapped and reserved words, and the write-only injector, read zero
  always_comb begin
    if (!win_hit) begin
      next_rd_data = SSE_RST_WORD;
    end else if (off == SSE_OFF_FLAGS) begin
      next_rd_data = {28'h0000000, flags};
    end else if (off == SSE_OFF_ENABLES) begin
      next_rd_data = {28'h0000000, enables};
    end else if (off == SSE_OFF_STATUS) begin
      next_rd_data = status_word;
    end else if (off == SSE_OFF_CONTROL) begin
      next_rd_data = 32'(control);
    end else if (off == SSE_OFF_POWER) begin
      next_rd_data = power;
    end else begin
      next_rd_data = SSE_RST_WORD;
    end
  end

  // Answer one cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= SSE_RST_WORD;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      rd_data <= req.rd ? next_rd_data : SSE_RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic rd_was_flags;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_was_flags <= 1'b0;
    end else begin
      rd_was_flags <= req.rd && win_hit && (off == SSE_OFF_FLAGS);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_flags_upper_zero: assert property (
    (rd_valid && rd_was_flags) |-> (rd_data[31:4] == 28'h0000000))
    else $error("event upper bits not zero");

  chk_pwr_change_sets: assert property (
    (primed && (sock.power_cycle_status != $past(sock.power_cycle_status))
     && !bus_reset_in) |=> flags[3])
    else $error("power cycle change not flagged");

  chk_det2_change_sets: assert property (
    (primed && $changed(sock.detect_two_status) && !bus_reset_in) |=> flags[2])
    else $error("detect two change not flagged");

  chk_det1_change_sets: assert property (
    (primed && $changed(sock.detect_one_status) && !bus_reset_in) |=> flags[1])
    else $error("detect one change not flagged");

  chk_card_fall_16bit: assert property (
    (primed && $fell(sock.card_status_in) && !sock.cardbus_card && !bus_reset_in)
    |=> flags[0])
    else $error("16-bit card falling edge not flagged");

  chk_inject_sets: assert property (
    (wr_inject && !bus_reset_in) |=> ((flags & $past(req.wdata[3:0])) == $past(req.wdata[3:0])))
    else $error("force write did not set flags");

  chk_bus_reset_clears: assert property (
    (bus_reset_in && !pme_en) |=> (flags == 4'h0) && (enables == 4'h0))
    else $error("bus reset left context bits");

  chk_pme_keeps_context: assert property (
    (bus_reset_in && pme_en && !req.wr) |=> (enables == $past(enables)))
    else $error("bus reset cleared mask under PME");

  chk_reset_exit_refl: assert property (
    (reset_exit && sock.detect_one_status && !bus_reset_in) |=> flags[1])
    else $error("still-present detect not re-flagged");

  chk_irq_tracks: assert property (
    ##1 (status_change_interrupt == |($past(flags) & $past(enables))))
    else $error("interrupt not OR of masked flags");

  chk_clear_all: assert property (
    (wr_flags && (req.wdata[3:0] == 4'hF) && (set_vec == 4'h0)) |=> (flags == 4'h0))
    else $error("write-one-clear failed");

  cov_irq_raise: cover property ($rose(status_change_interrupt));
  cov_inject: cover property (wr_inject ##2 status_change_interrupt);
  cov_card_cycle: cover property ($rose(sock.card_reset_in) ##[1:20] reset_exit);
  cov_read_flags: cover property (rd_valid && rd_was_flags && (rd_data != 32'h0000_0000));

endmodule // sse_bank
`default_nettype wire

// File: sse_pkg.sv
// Purpose: Shared constants and carriers for the socket status event bank
// Assumes: Registers sit in a 4 KB memory window above the socket base
// Notes:   Offsets are byte addresses of aligned 32-bit words
// What this block does
// - Event bits 31 to 4 read zero
// - Power cycle change sets bit 3; W1C
// - Detect two change sets bit 2; W1C
// - Detect one change sets bit 1; W1C
// - Bit 0: rising CardBus, both edges 16-bit
// - Force-event write of 1 sets event bit
// - Bus reset clears all event bits when PME off
// - Leaving card reset re-sets still-present detect and card status events
// - Any unmasked set bit raises the interrupt
// - Events flag change only; status read separately
// - Context bits survive bus reset when PME on
// - Registers at 00h,04h,08h,0Ch,10h,20h; 14h-1Ch reserved
// - Register set lives at the memory base address
// - Mask gates interrupt only, never event setting
package sse_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int SSE_WIN_BITS = 12;
  localparam logic [11:0] SSE_OFF_FLAGS = 12'h000;
  localparam logic [11:0] SSE_OFF_ENABLES = 12'h004;
  localparam logic [11:0] SSE_OFF_STATUS = 12'h008;
  localparam logic [11:0] SSE_OFF_INJECT = 12'h00C;
  localparam logic [11:0] SSE_OFF_CONTROL = 12'h010;
  localparam logic [11:0] SSE_OFF_POWER = 12'h020;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int SSE_NUM_EVT = 4;
  localparam int SSE_BIT_CARD = 0;
  localparam int SSE_BIT_DET1 = 1;
  localparam int SSE_BIT_DET2 = 2;
  localparam int SSE_BIT_PWR = 3;
  localparam int SSE_BIT_PME_EN = 0;
  localparam logic [31:0] SSE_STATUS_CAPS = 32'h3000_0000;
  localparam logic [31:0] SSE_RST_WORD = 32'h0000_0000;
  localparam logic [3:0] SSE_RST_NIBBLE = 4'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic rd;
    logic [3:0] be;
    logic [31:0] wdata;
  } sse_req_s;

  typedef struct packed {
    logic power_cycle_status;
    logic detect_two_status;
    logic detect_one_status;
    logic card_status_in;
    logic cardbus_card;
    logic card_reset_in;
  } sse_sock_s;

endpackage

// File: sse_flag_cell.sv
// Purpose: One sticky event flag with set, write-one-clear and context clear
// Assumes: All controls are synchronous to ref_clk
// Notes:   Set beats write-one-clear; context clear beats both
`timescale 1ns/1ns
`default_nettype none
module sse_flag_cell (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ctx_clear,
  input wire logic set_evt,
  input wire logic w1c,
  output logic flag
);

  logic next_flag;

  // Priority: reset clear, then hardware set, then software clear
  assign next_flag = ctx_clear ? 1'b0 : (set_evt ? 1'b1 : (w1c ? 1'b0 : flag));

  // Flag register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_set_beats_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (set_evt && w1c && !ctx_clear) |=> flag)
    else $error("event lost when set met clear");

endmodule // sse_flag_cell
`default_nettype wire

// File: sse_card_model.sv
// Purpose: Behavioural socket side: card detect, card status, power and reset levels
// Assumes: The bench picks the levels; the model launches them just after an edge
// Notes:   Levels hold between changes, as real socket pins do
`timescale 1ns/1ns
`default_nettype none
module sse_card_model
  import sse_pkg::*;
(
  input wire logic ref_clk,
  input wire sse_sock_s want,
  output var sse_sock_s sock
);
  // --------------------------------------------------------------
  // Pin launch
  // --------------------------------------------------------------
  // Registered so that no pin ever changes on the sampling edge itself
  initial sock = '0;
  always @(posedge ref_clk) begin
    sock <= want;
  end
endmodule // sse_card_model
`default_nettype wire

// File: sse_bank_test.sv
// Purpose: Self-checking bench for the socket status event bank
// Assumes: One clock; register answers come one cycle after the read strobe
// Notes:   Read results are queued at issue and compared when rd_valid shows
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD %0t value %h expected %h", $time, got, exp); end end
module sse_bank_test
  import sse_pkg::*;
;
  localparam logic [31:0] BASE = 32'h8000_3000;
  logic ref_clk;
  logic rst;
  logic bus_reset_in;
  logic [31:0] socket_base;
  sse_req_s req;
  sse_sock_s want;
  sse_sock_s sock;
  logic [31:0] rd_data;
  logic rd_valid;
  logic irq;
  int fail_count;
  int cmp_count;
  int cycle_count;
  int unsigned seed;
  logic [31:0] exp_q[$];
  logic [31:0] head;
  logic [31:0] ctl;
  logic [3:0] lv;
  logic [3:0] nlv;
  logic [3:0] ex;
  logic cb;
  logic [11:0] offs [10] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h020,
                             12'h014, 12'h018, 12'h01C, 12'h100};

  sse_card_model u_sse_card_model (.ref_clk(ref_clk), .want(want), .sock(sock));
  sse_bank u_sse_bank (.ref_clk(ref_clk), .rst(rst), .bus_reset_in(bus_reset_in),
    .socket_base(socket_base), .req(req), .sock(sock), .rd_data(rd_data),
    .rd_valid(rd_valid), .status_change_interrupt(irq));

  // --------------------------------------------------------------
  // Clock, watchdog and answer checker
  // --------------------------------------------------------------
  // 25 MHz reference
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      fail_count++;
      $display("BAD %0t watchdog ceiling reached", $time);
      summarize();
    end
  end

  // Oldest note is matched against each answer as it appears
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("BAD %0t answer with no read pending", $time);
      end else begin
        head = exp_q.pop_front();
        `CHK(rd_data, head)
      end
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  // One strobe per access; an idle edge follows so strobes never collide
  task automatic acc(input logic w, input logic [11:0] off, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge ref_clk);
    req.wr <= w;
    req.rd <= ~w;
    req.addr <= BASE | {20'h0, off};
    req.be <= be;
    req.wdata <= d;
    @(posedge ref_clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] off, input logic [31:0] d);
    acc(1'b1, off, d, 4'hF);
  endtask

  task automatic rd(input logic [11:0] off, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, off, 32'h0, 4'h0);
  endtask

  // Socket levels, then time for the flag and the interrupt to settle
  task automatic put(input logic [3:0] l, input logic c, input logic r);
    @(posedge ref_clk);
    want <= {l[3], l[2], l[1], l[0], c, r};
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    fail_count = 0;
    cmp_count = 0;
    cycle_count = 0;
    rst = 1'b1;
    bus_reset_in = 1'b0;
    socket_base = BASE;
    req = '0;
    want = '0;
    lv = 4'h0;
    cb = 1'b1;
    seed = $urandom(32'h2880);
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // Reset values, reserved words and an unmapped offset
    foreach (offs[i]) rd(offs[i], (i == 2) ? SSE_STATUS_CAPS : 32'h0);
    wr(SSE_OFF_INJECT, 32'hFFFF_FFFF);
    rd(SSE_OFF_FLAGS, 32'h0000_000F);
    rd(SSE_OFF_STATUS, SSE_STATUS_CAPS);
    acc(1'b1, SSE_OFF_FLAGS, 32'hF, 4'hE);
    rd(SSE_OFF_FLAGS, 32'h0000_000F);
    // Moving the base hides the set
    socket_base <= 32'h4000_0000;
    rd(SSE_OFF_FLAGS, 32'h0);
    socket_base <= BASE;
    for (int i = 0; i < 4; i++) begin
      wr(SSE_OFF_FLAGS, 32'h1 << i);
      rd(SSE_OFF_FLAGS, 32'hF & ~((32'h2 << i) - 1));
    end
    // Random socket changes with every event masked
    for (int k = 0; k < 16; k++) begin
      nlv = 4'($urandom());
      cb = 1'($urandom());
      put(lv, cb, 1'b0);
      ex = (nlv ^ lv) & 4'hE;
      ex[0] = (nlv[0] & ~lv[0]) | (~cb & (nlv[0] ^ lv[0]));
      lv = nlv;
      put(lv, cb, 1'b0);
      rd(SSE_OFF_FLAGS, {28'h0, ex});
      rd(SSE_OFF_STATUS, SSE_STATUS_CAPS | {28'h0, lv});
      `CHK(irq, 1'b0)
      wr(SSE_OFF_FLAGS, 32'hF);
    end
    // Each mask bit gates only its own flag
    for (int i = 0; i < 4; i++) begin
      wr(SSE_OFF_FLAGS, 32'hF);
      wr(SSE_OFF_ENABLES, 32'h1 << i);
      wr(SSE_OFF_INJECT, 32'hF ^ (32'h1 << i));
      repeat (3) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      wr(SSE_OFF_INJECT, 32'h1 << i);
      repeat (3) @(posedge ref_clk);
      `CHK(irq, 1'b1)
    end
    wr(SSE_OFF_ENABLES, 32'hFFFF_FFFF);
    rd(SSE_OFF_ENABLES, 32'h0000_000F);
    // Leaving card reset with the card still present
    lv = 4'h7;
    put(lv, 1'b1, 1'b0);
    put(lv, 1'b1, 1'b1);
    wr(SSE_OFF_FLAGS, 32'hF);
    put(lv, 1'b1, 1'b0);
    rd(SSE_OFF_FLAGS, 32'h7);
    // Context kept through a bus reset only while PME is on
    ctl = $urandom();
    wr(SSE_OFF_CONTROL, ctl);
    // Only the enabled byte lane of a control write may land
    acc(1'b1, SSE_OFF_CONTROL, ~ctl, 4'h2);
    ctl[15:8] = ~ctl[15:8];
    wr(SSE_OFF_FLAGS, 32'hF);
    wr(SSE_OFF_INJECT, 32'hA);
    wr(SSE_OFF_ENABLES, 32'h3);
    for (int p = 1; p >= 0; p--) begin
      wr(SSE_OFF_POWER, 32'(p));
      @(posedge ref_clk);
      bus_reset_in <= 1'b1;
      @(posedge ref_clk);
      bus_reset_in <= 1'b0;
      rd(SSE_OFF_FLAGS, p ? 32'hA : 32'h0);
      rd(SSE_OFF_ENABLES, p ? 32'h3 : 32'h0);
      rd(SSE_OFF_CONTROL, p ? ctl : 32'h0);
      rd(SSE_OFF_POWER, 32'(p));
    end
    wr(SSE_OFF_POWER, 32'h1);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(SSE_OFF_POWER, 32'h0);
    repeat (4) @(posedge ref_clk);
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("BAD %0t reads left without an answer", $time);
    end
    summarize();
  end
endmodule // sse_bank_test
`default_nettype wire
